// ===== core/dst_params.svh
`ifndef DST_PARAMS_SVH
`define DST_PARAMS_SVH

// register port geometry and sample data width
`define DST_AW              5
`define DST_DW              8
`define DST_DATA_W          16

// register offsets
`define DST_REG_DIC         5'h03
`define DST_REG_DELAY       5'h04
`define DST_REG_MARGIN      5'h05
`define DST_REG_SYNC        5'h06
`define DST_REG_IRQ         5'h19

// data_interface_control fields
`define DST_DIC_MODE        7
`define DST_DIC_REF         0
`define DST_DIC_RESET       8'h80

// output clock delay register fields
`define DST_DLY_EN          7
`define DST_DLY_RESET       8'h00

// interrupt_status fields
`define DST_IRQ_DATA        7
`define DST_IRQ_SYNC        6
`define DST_IRQ_TYPE        5
`define DST_IRQ_MDATA       3
`define DST_IRQ_MSYNC       2
`define DST_IRQ_RESET       8'h00

// sync edge divider: highest valid code
`define DST_RATIO_MAX       3'h4

`endif

// ===== core/dst_pkg.sv
`include "dst_params.svh"

package dst_pkg;

	// state of the converter-clock side
	typedef struct packed {
		logic [1:0]            sync_q;
		logic [1:0]            early_q;
		logic [1:0]            late_q;
		logic                  sync_d;
		logic [3:0]            edge_cnt;
		logic                  init_pulse;
		logic [4:0]            clk_state;
		logic [`DST_DW-1:0]    dic;
		logic [`DST_DW-1:0]    delay;
		logic [`DST_DW-1:0]    margin;
		logic [`DST_DW-1:0]    sync_cfg;
		logic                  data_err;
		logic                  sync_err;
		logic                  err_type;
		logic                  mask_data;
		logic                  mask_sync;
		logic                  req_tgl;
		logic [2:0]            ack_q;
		logic                  busy;
		logic [`DST_DW-1:0]    rdata;
		logic                  irq_oe;
	} dst_core_t;

	// state of the data-link side
	typedef struct packed {
		logic [2:0]            req_q;
		logic                  pending;
		logic                  res_err;
		logic                  res_type;
		logic                  ack_tgl;
	} dst_link_t;

endpackage

// ===== core/dst_monitor.sv
`timescale 1ns/1ps
`include "dst_params.svh"
// Operation
// - flag error when early/late copy differs
// - four-bit data margin sets copy offset
// - error type bit: 0 hold, 1 setup
// - checking only with output-clock data timing
// - manual mode keeps delay code as written
// - delay enable resets 0, code output not gated by it
// - delay line monotonic from 00000 to 11111
// - manual mode arms check, error raises interrupt
// - one data check per configuration
// - data margin or delay code change starts new check
// - init pulse one cycle, loads preset
// - periodic pulses reload the preset
// - edge divider 1,2,4,8,16; 101-111 invalid
// - preset increment advances clocks one cycle
// - sync sampled on sample clock, pulse or periodic
// - sync margin sets sync error threshold
// - open-drain low interrupt on either flag
// - each flag has its own mask
// - flags latched until read or overwritten
module dst_monitor
(
	input  wire logic                        core_clk,
	input  wire logic                        rstn,
	input  wire logic                        link_clk,
	input  wire logic [`DST_AW-1:0]          reg_addr,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	input  wire logic [`DST_DW-1:0]          reg_wdata,
	output logic      [`DST_DW-1:0]          reg_rdata,
	input  wire logic [`DST_DATA_W-1:0]      data_in,
	input  wire logic [`DST_DATA_W-1:0]      data_early,
	input  wire logic [`DST_DATA_W-1:0]      data_late,
	input  wire logic                        sync_in,
	input  wire logic                        sync_early,
	input  wire logic                        sync_late,
	output logic      [3:0]                  data_margin_tap,
	output logic      [3:0]                  sync_margin_tap,
	output logic                             delay_line_en,
	output logic      [4:0]                  output_clock_delay_code,
	output logic      [4:0]                  clk_state,
	output logic                             init_pulse,
	output logic                             internal_sample_strobe,
	output logic                             irq_n_o,
	output logic                             irq_n_oe
);
	import dst_pkg::*;

	logic [1:0]  rst_core_q;
	logic [1:0]  rst_link_q;
	logic        rst_core_n;
	logic        rst_link_n;
	dst_core_t   cs;
	dst_core_t   next_cs;
	dst_link_t   ls;
	dst_link_t   next_ls;
	logic        sync_rise;
	logic        ack_seen;
	logic        wr_dic;
	logic        wr_dly;
	logic        wr_mgn;
	logic        wr_irq;
	logic        rd_irq;
	logic        cfg_change;
	logic        enter_manual;
	logic        check_allowed;
	logic [3:0]  edge_goal;
	logic        set_data;
	logic        set_sync;

	// reset release through two flops per domain
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rst_core_q <= 2'h0;
		else
			rst_core_q <= {rst_core_q[0], 1'b1};
	end

	always_ff @(posedge link_clk or negedge rstn)
	begin
		if (!rstn)
			rst_link_q <= 2'h0;
		else
			rst_link_q <= {rst_link_q[0], 1'b1};
	end

	assign rst_core_n = rst_core_q[1];
	assign rst_link_n = rst_link_q[1];

	// decoded register accesses
	assign wr_dic = reg_wr && (reg_addr == `DST_REG_DIC);
	assign wr_dly = reg_wr && (reg_addr == `DST_REG_DELAY);
	assign wr_mgn = reg_wr && (reg_addr == `DST_REG_MARGIN);
	assign wr_irq = reg_wr && (reg_addr == `DST_REG_IRQ);
	assign rd_irq = reg_rd && (reg_addr == `DST_REG_IRQ);

	// only a real change restarts the check, rewriting the same value does not
	assign cfg_change = (wr_dly && (reg_wdata[4:0] != cs.delay[4:0]))
		|| (wr_mgn && (reg_wdata[7:4] != cs.margin[7:4]));
	// entering manual while timed to the reference input must not start a check
	assign enter_manual = wr_dic && cs.dic[`DST_DIC_MODE]
		&& !reg_wdata[`DST_DIC_MODE] && !reg_wdata[`DST_DIC_REF];
	// checks only make sense while data is timed to the output data clock
	assign check_allowed = !cs.dic[`DST_DIC_MODE] && !cs.dic[`DST_DIC_REF];

	// sync edge seen on the second flop's history only
	assign sync_rise = cs.sync_q[1] && !cs.sync_d;
	assign edge_goal = 4'(({1'b0, 4'h1} << cs.sync_cfg[7:5]) - 5'h01);
	assign ack_seen = cs.ack_q[2] ^ cs.ack_q[1];

	// hardware events that set the flags
	assign set_data = ack_seen && cs.busy && ls.res_err;
	assign set_sync = sync_rise && ((cs.early_q[1] != cs.sync_q[1])
		|| (cs.late_q[1] != cs.sync_q[1]));

	// converter-clock next state
	always_comb
	begin
		next_cs = cs;
		next_cs.sync_q = {cs.sync_q[0], sync_in};
		next_cs.early_q = {cs.early_q[0], sync_early};
		next_cs.late_q = {cs.late_q[0], sync_late};
		next_cs.sync_d = cs.sync_q[1];
		next_cs.ack_q = {cs.ack_q[1:0], ls.ack_tgl};

		// edge divider: invalid codes never produce a pulse
		next_cs.init_pulse = 1'b0;
		if (sync_rise && (cs.sync_cfg[7:5] <= `DST_RATIO_MAX))
		begin
			if (cs.edge_cnt >= edge_goal)
			begin
				next_cs.edge_cnt = 4'h0;
				next_cs.init_pulse = 1'b1;
			end
			else
				next_cs.edge_cnt = 4'(cs.edge_cnt + 4'h1);
		end

		// 32-state clock generator; a pulse loads the preset
		if (cs.init_pulse)
			next_cs.clk_state = cs.sync_cfg[4:0];
		else
			next_cs.clk_state = 5'(cs.clk_state + 5'h01);

		// register writes; the delay code is kept exactly as written
		if (wr_dic)
			next_cs.dic = reg_wdata;
		if (wr_dly)
			next_cs.delay = reg_wdata;
		if (wr_mgn)
			next_cs.margin = reg_wdata;
		if (reg_wr && (reg_addr == `DST_REG_SYNC))
			next_cs.sync_cfg = reg_wdata;

		// one check per configuration: start, then wait for the link answer
		if ((enter_manual || (cfg_change && check_allowed)) && !cs.busy)
		begin
			next_cs.busy = 1'b1;
			next_cs.req_tgl = !cs.req_tgl;
		end
		else if (ack_seen)
			next_cs.busy = 1'b0;
		else if (!check_allowed)
			next_cs.busy = 1'b0;

		// flags: clear by read or overwrite, but a set in the same cycle wins
		if (wr_irq)
		begin
			next_cs.data_err = reg_wdata[`DST_IRQ_DATA];
			next_cs.sync_err = reg_wdata[`DST_IRQ_SYNC];
			next_cs.err_type = reg_wdata[`DST_IRQ_TYPE];
			next_cs.mask_data = reg_wdata[`DST_IRQ_MDATA];
			next_cs.mask_sync = reg_wdata[`DST_IRQ_MSYNC];
		end
		else if (rd_irq)
		begin
			next_cs.data_err = 1'b0;
			next_cs.sync_err = 1'b0;
		end
		if (set_data)
		begin
			next_cs.data_err = 1'b1;
			next_cs.err_type = ls.res_type;
		end
		if (set_sync)
			next_cs.sync_err = 1'b1;

		// open-drain request follows unmasked flags
		next_cs.irq_oe = (next_cs.data_err && !next_cs.mask_data)
			|| (next_cs.sync_err && !next_cs.mask_sync);

		// read data, one cycle after the strobe
		unique case (reg_addr)
			`DST_REG_DIC:    next_cs.rdata = cs.dic;
			`DST_REG_DELAY:  next_cs.rdata = cs.delay;
			`DST_REG_MARGIN: next_cs.rdata = cs.margin;
			`DST_REG_SYNC:   next_cs.rdata = cs.sync_cfg;
			`DST_REG_IRQ:    next_cs.rdata = {cs.data_err, cs.sync_err, cs.err_type, 1'b0,
				cs.mask_data, cs.mask_sync, 2'h0};
			default:         next_cs.rdata = 8'h00;
		endcase
		if (!reg_rd)
			next_cs.rdata = cs.rdata;
	end

	always_ff @(posedge core_clk or negedge rst_core_n)
	begin
		if (!rst_core_n)
		begin
			cs <= '0;
			cs.dic <= `DST_DIC_RESET;
			cs.delay <= `DST_DLY_RESET;
		end
		else
			cs <= next_cs;
	end

	// link side: compare margin copies with the real sample once per request
	always_comb
	begin
		next_ls = ls;
		next_ls.req_q = {ls.req_q[1:0], cs.req_tgl};
		if (ls.req_q[2] ^ ls.req_q[1])
			next_ls.pending = 1'b1;
		else if (ls.pending)
		begin
			next_ls.pending = 1'b0;
			// early copy off means data settles late: a setup fault
			next_ls.res_err = (data_early != data_in) || (data_late != data_in);
			next_ls.res_type = (data_early != data_in);
			next_ls.ack_tgl = !ls.ack_tgl;
		end
	end

	always_ff @(posedge link_clk or negedge rst_link_n)
	begin
		if (!rst_link_n)
			ls <= '0;
		else
			ls <= next_ls;
	end

	// outputs from flops; strobe decoded from clk_state, irq_n_o tied low
	assign reg_rdata = cs.rdata;
	assign data_margin_tap = cs.margin[7:4];
	assign sync_margin_tap = cs.margin[3:0];
	assign delay_line_en = cs.delay[`DST_DLY_EN];
	assign output_clock_delay_code = cs.delay[4:0];
	assign clk_state = cs.clk_state;
	assign init_pulse = cs.init_pulse;
	assign internal_sample_strobe = (cs.clk_state == 5'h00);
	assign irq_n_o = 1'b0;
	assign irq_n_oe = cs.irq_oe;

	property p_init_load;
		@(posedge core_clk) disable iff (!rst_core_n)
		cs.init_pulse |=> (cs.clk_state == $past(cs.sync_cfg[4:0]));
	endproperty
	a_init_load: assert property (p_init_load) else $error("preset not loaded");

	property p_free_run;
		@(posedge core_clk) disable iff (!rst_core_n)
		!cs.init_pulse |=> (cs.clk_state == 5'($past(cs.clk_state) + 5'h01));
	endproperty
	a_free_run: assert property (p_free_run) else $error("clock state skipped");

	property p_pulse_single;
		@(posedge core_clk) disable iff (!rst_core_n)
		cs.init_pulse |=> !cs.init_pulse;
	endproperty
	a_pulse_single: assert property (p_pulse_single) else $error("pulse too wide");

	property p_ratio_invalid;
		@(posedge core_clk) disable iff (!rst_core_n)
		(cs.sync_cfg[7:5] > `DST_RATIO_MAX) [*2] |-> !cs.init_pulse;
	endproperty
	a_ratio_invalid: assert property (p_ratio_invalid) else $error("pulse on bad code");

	property p_irq_follow;
		@(posedge core_clk) disable iff (!rst_core_n)
		irq_n_oe == ((cs.data_err && !cs.mask_data) || (cs.sync_err && !cs.mask_sync));
	endproperty
	a_irq_follow: assert property (p_irq_follow) else $error("irq mismatch");

	property p_mask;
		@(posedge core_clk) disable iff (!rst_core_n)
		(cs.mask_data && cs.mask_sync) |-> !irq_n_oe;
	endproperty
	a_mask: assert property (p_mask) else $error("masked irq active");

	property p_latch;
		@(posedge core_clk) disable iff (!rst_core_n)
		(cs.data_err && !rd_irq && !wr_irq) |=> cs.data_err;
	endproperty
	a_latch: assert property (p_latch) else $error("flag lost");

	property p_delay_kept;
		@(posedge core_clk) disable iff (!rst_core_n)
		(!cs.dic[`DST_DIC_MODE] && !wr_dly) |=> $stable(output_clock_delay_code);
	endproperty
	a_delay_kept: assert property (p_delay_kept) else $error("delay code altered");

	property p_check_start;
		@(posedge core_clk) disable iff (!rst_core_n)
		(cfg_change && check_allowed && !cs.busy) |=> (cs.busy && $changed(cs.req_tgl));
	endproperty
	a_check_start: assert property (p_check_start) else $error("check not started");

	property p_ref_block;
		@(posedge core_clk) disable iff (!rst_core_n)
		cs.dic[`DST_DIC_REF] [*2] |-> !cs.busy;
	endproperty
	a_ref_block: assert property (p_ref_block) else $error("check with ref clock");

	property p_data_set;
		@(posedge core_clk) disable iff (!rst_core_n)
		set_data |=> cs.data_err;
	endproperty
	a_data_set: assert property (p_data_set) else $error("data flag not set");

	property p_err_type;
		@(posedge core_clk) disable iff (!rst_core_n)
		set_data |=> (cs.err_type == $past(ls.res_type));
	endproperty
	a_err_type: assert property (p_err_type) else $error("error type wrong");

	property p_read_clear;
		@(posedge core_clk) disable iff (!rst_core_n)
		(rd_irq && !wr_irq && !set_data) |=> !cs.data_err;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("flag not cleared");

	property p_irq_raise;
		@(posedge core_clk) disable iff (!rst_core_n)
		(set_data && !cs.mask_data && !wr_irq) |=> irq_n_oe;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");

	property p_sync_set;
		@(posedge core_clk) disable iff (!rst_core_n)
		set_sync |=> cs.sync_err;
	endproperty
	a_sync_set: assert property (p_sync_set) else $error("sync flag not set");

	property p_delay_write;
		@(posedge core_clk) disable iff (!rst_core_n)
		wr_dly |=> (output_clock_delay_code == $past(reg_wdata[4:0]));
	endproperty
	a_delay_write: assert property (p_delay_write) else $error("delay code wrong");

	property p_delay_enable;
		@(posedge core_clk) disable iff (!rst_core_n)
		wr_dly |=> (delay_line_en == $past(reg_wdata[`DST_DLY_EN]));
	endproperty
	a_delay_enable: assert property (p_delay_enable) else $error("enable wrong");

	property p_one_check;
		@(posedge core_clk) disable iff (!rst_core_n)
		cs.busy |=> $stable(cs.req_tgl);
	endproperty
	a_one_check: assert property (p_one_check) else $error("second check started");

	property p_manual_start;
		@(posedge core_clk) disable iff (!rst_core_n)
		(enter_manual && !cs.busy) |=> (cs.busy && $changed(cs.req_tgl));
	endproperty
	a_manual_start: assert property (p_manual_start) else $error("manual no check");

	property p_link_once;
		@(posedge link_clk) disable iff (!rst_link_n)
		!ls.pending |=> $stable(ls.ack_tgl);
	endproperty
	a_link_once: assert property (p_link_once) else $error("spurious answer");

	property p_irq_release;
		@(posedge core_clk) disable iff (!rst_core_n)
		(rd_irq && !wr_irq && !set_data && !set_sync) |=> !irq_n_oe;
	endproperty
	a_irq_release: assert property (p_irq_release) else $error("irq not released");

endmodule

// ===== tb/dst_far_end.sv
`timescale 1ns/1ps
`include "dst_params.svh"
// data source and sync master on the far side of the monitor
module dst_far_end
(
	input  wire logic                   core_clk,
	input  wire logic                   link_clk,
	input  wire logic                   err_early,
	input  wire logic                   err_late,
	input  wire logic                   sync_run,
	input  wire logic                   sync_skew,
	output logic      [`DST_DATA_W-1:0] data_in,
	output logic      [`DST_DATA_W-1:0] data_early,
	output logic      [`DST_DATA_W-1:0] data_late,
	output logic                        sync_in,
	output logic                        sync_early,
	output logic                        sync_late
);
	logic [`DST_DATA_W-1:0] cnt = 16'h0000;
	logic [4:0]             phase = 5'h00;
	// data changes every link cycle so a stuck copy is noticed
	always_ff @(posedge link_clk)
		cnt <= cnt + 16'h0001;
	assign data_in    = cnt;
	assign data_early = cnt ^ {15'h0000, err_early};
	assign data_late  = cnt ^ {15'h0000, err_late};
	// one rise every 32 sample cycles, low while stopped
	always_ff @(posedge core_clk)
		phase <= sync_run ? phase + 5'h01 : 5'h00;
	assign sync_in    = sync_run && (phase < 5'h04);
	assign sync_early = sync_in;
	assign sync_late  = sync_in ^ sync_skew;
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "dst_params.svh"
module tb;
	logic core_clk, link_clk, rstn, reg_wr, reg_rd;
	logic err_early, err_late, sync_run, sync_skew;
	logic [4:0] reg_addr, code, clk_state;
	logic [7:0] reg_wdata, reg_rdata;
	logic [3:0] dtap, stap;
	logic [15:0] d_in, d_e, d_l;
	logic s_in, s_e, s_l, den, init_pulse, strobe, irq_n_o, irq_n_oe, irq_pin;
	int err_count = 0;
	int checks = 0;
	int n;
	dst_far_end dst_far_end_inst (.core_clk(core_clk), .link_clk(link_clk), .err_early(err_early),
		.err_late(err_late), .sync_run(sync_run), .sync_skew(sync_skew), .data_in(d_in),
		.data_early(d_e), .data_late(d_l), .sync_in(s_in), .sync_early(s_e), .sync_late(s_l));
	dst_monitor dst_monitor_inst (.core_clk(core_clk), .rstn(rstn), .link_clk(link_clk),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .data_in(d_in), .data_early(d_e), .data_late(d_l),
		.sync_in(s_in), .sync_early(s_e), .sync_late(s_l), .data_margin_tap(dtap),
		.sync_margin_tap(stap), .delay_line_en(den), .output_clock_delay_code(code),
		.clk_state(clk_state), .init_pulse(init_pulse), .internal_sample_strobe(strobe),
		.irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
	// board pull-up on the open-drain interrupt line
	assign irq_pin = irq_n_oe ? irq_n_o : 1'b1;
	// sample clock and an unrelated link clock
	initial
	begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial
	begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end
	task summarize;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// register cycles start and end just after a rising edge
	task wr(input logic [4:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task rd(input logic [4:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		chk(reg_rdata, exp);
		@(posedge core_clk);
	endtask
	task skip(input int c);
		repeat (c) @(posedge core_clk);
	endtask
	// bounded waits look at settled values on the falling edge
	task wait_oe(input logic v);
		n = 0;
		do begin @(negedge core_clk); n++; end while (n < 300 && irq_n_oe !== v);
		if (irq_n_oe !== v)
		begin
			err_count++;
			summarize();
		end
		@(posedge core_clk);
	endtask
	task gap;
		n = 0;
		do begin @(negedge core_clk); n++; end while (n < 200 && init_pulse !== 1'b1);
		@(posedge core_clk);
	endtask
	task t_reset;
		rd(`DST_REG_DIC, 8'h80);
		rd(`DST_REG_DELAY, 8'h00);
		rd(`DST_REG_IRQ, 8'h00);
		rd(5'h1F, 8'h00);
		chk({7'h00, irq_n_oe}, 8'h00);
		chk({7'h00, irq_pin}, 8'h01);
		$display("test reset done");
	endtask
	task t_delay;
		wr(`DST_REG_DELAY, 8'h9F);
		chk({3'h0, code}, 8'h1F);
		chk({7'h00, den}, 8'h01);
		wr(`DST_REG_DELAY, 8'h00);
		chk({3'h0, code}, 8'h00);
		chk({7'h00, den}, 8'h00);
		wr(`DST_REG_DELAY, 8'h9E);
		$display("test delay done");
	endtask
	task t_data;
		err_early <= 1'b1;
		wr(`DST_REG_DIC, 8'h00);
		wait_oe(1'b1);
		chk({7'h00, irq_pin}, 8'h00);
		rd(`DST_REG_IRQ, 8'hA0);
		skip(2);
		chk({7'h00, irq_n_oe}, 8'h00);
		chk({7'h00, irq_pin}, 8'h01);
		rd(`DST_REG_IRQ, 8'h20);
		err_early <= 1'b0;
		err_late <= 1'b1;
		wr(`DST_REG_IRQ, 8'h08);
		wr(`DST_REG_DELAY, 8'h9D);
		skip(40);
		chk({7'h00, irq_n_oe}, 8'h00);
		rd(`DST_REG_IRQ, 8'h88);
		err_late <= 1'b0;
		wr(`DST_REG_IRQ, 8'h00);
		wr(`DST_REG_MARGIN, 8'h30);
		skip(40);
		rd(`DST_REG_IRQ, 8'h00);
		chk({4'h0, dtap}, 8'h03);
		wr(`DST_REG_DIC, 8'h01);
		err_late <= 1'b1;
		wr(`DST_REG_DELAY, 8'h9C);
		skip(40);
		rd(`DST_REG_IRQ, 8'h00);
		err_late <= 1'b0;
		$display("test data done");
	endtask
	task t_sync;
		wr(`DST_REG_SYNC, 8'h05);
		sync_run <= 1'b1;
		gap();
		@(negedge core_clk);
		chk({3'h0, clk_state}, 8'h05);
		chk({7'h00, init_pulse}, 8'h00);
		@(posedge core_clk);
		gap();
		chk(n[7:0], 8'd31);
		@(negedge core_clk);
		chk({3'h0, clk_state}, 8'h05);
		@(posedge core_clk);
		wr(`DST_REG_SYNC, 8'h25);
		skip(24);
		@(negedge core_clk);
		chk({7'h00, strobe}, 8'h01);
		chk({3'h0, clk_state}, 8'h00);
		@(posedge core_clk);
		gap();
		gap();
		chk(n[7:0], 8'd64);
		wr(`DST_REG_SYNC, 8'hA5);
		gap();
		chk(n[7:0], 8'd200);
		wr(`DST_REG_MARGIN, 8'h34);
		chk({4'h0, stap}, 8'h04);
		sync_skew <= 1'b1;
		wr(`DST_REG_SYNC, 8'h05);
		wait_oe(1'b1);
		// controller recovery: lower the sync margin, then remove the skew and stop sync
		wr(`DST_REG_MARGIN, 8'h30);
		chk({4'h0, stap}, 8'h00);
		sync_skew <= 1'b0;
		sync_run <= 1'b0;
		skip(10);
		rd(`DST_REG_IRQ, 8'h40);
		skip(2);
		chk({7'h00, irq_n_oe}, 8'h00);
		sync_run <= 1'b1;
		skip(70);
		rd(`DST_REG_IRQ, 8'h00);
		sync_run <= 1'b0;
		$display("test sync done");
	endtask
	initial
	begin
		rstn = 1'b0;
		{reg_wr, reg_rd, err_early, err_late, sync_run, sync_skew} = 6'h00;
		reg_addr = 5'h00;
		reg_wdata = 8'h00;
		skip(3);
		rstn <= 1'b1;
		skip(3);
		t_reset();
		t_delay();
		t_data();
		t_sync();
		summarize();
	end
endmodule
